// file: hdl/asp_consts.vh
// Register map, field positions, codes and reset values of the audio port.
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
`define ASP_OFF_CTRL 8'h00
`define ASP_OFF_CLKDIV 8'h04
`define ASP_OFF_TDM 8'h08
`define ASP_OFF_TXDATA 8'h0C
`define ASP_OFF_RXDATA 8'h10
`define ASP_OFF_STATUS 8'h14
`define ASP_OFF_INTSTAT 8'h18
`define ASP_OFF_INTMASK 8'h1C
`define ASP_CTRL_W 11
`define ASP_CTRL_TXEN 0
`define ASP_CTRL_RXEN 1
`define ASP_CTRL_MASTER 2
`define ASP_CTRL_FMT 4:3
`define ASP_CTRL_SIZE 6:5
`define ASP_CTRL_ZERO 7
`define ASP_CTRL_RXRST 8
`define ASP_CTRL_TXDMA 9
`define ASP_CTRL_RXDMA 10
`define ASP_CTRL_RST 11'h100
`define ASP_CLKDIV_RST 8'h07
`define ASP_TDM_W 5
`define ASP_TDM_CH 2:0
`define ASP_TDM_SLOT 4:3
`define ASP_TDM_RST 5'h1F
`define ASP_FMT_STD 2'h0
`define ASP_FMT_LJ 2'h1
`define ASP_FMT_RJ 2'h2
`define ASP_FMT_TDM 2'h3
`define ASP_STD_SLOTW 6'h20
`define ASP_STD_LAST 3'h1
`define ASP_WORD 6'h20
`define ASP_INT_W 2
`define ASP_INT_RXOVF 0
`define ASP_INT_TXUND 1
`endif

// file: hdl/asp_fifo.v
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module asp_fifo #(
  parameter W = 32,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire wr_valid,
  input wire [W-1:0] wr_data,
  output wire wr_ready,
  output wire rd_valid,
  input wire rd_ready,
  output wire [W-1:0] rd_data
);
  reg [W-1:0] mem_ff [0:(1<<AW)-1];
  reg [AW:0] wp_ff;
  reg [AW:0] rp_ff;
  wire do_wr;
  wire do_rd;

  assign wr_ready = !((wp_ff[AW] != rp_ff[AW]) &&
                      (wp_ff[AW-1:0] == rp_ff[AW-1:0]));
  assign rd_valid = (wp_ff != rp_ff);
  assign rd_data = mem_ff[rp_ff[AW-1:0]];
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_ready && rd_valid;

  always @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wp_ff[AW-1:0]] <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_ff <= {(AW+1){1'b0}};
      rp_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_ff <= wp_ff + {{AW{1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rp_ff <= rp_ff + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// file: hdl/asp_top.v
// Full-duplex serial audio port with APB registers, FIFOs and DMA requests.
`timescale 1ns/1ns
`include "asp_consts.vh"

module asp_top #(
  parameter FIFO_AW = 3
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire bclk_i,
  output wire bclk_o,
  output wire bclk_oe,
  input wire fs_i,
  output wire fs_o,
  output wire fs_oe,
  input wire sdin,
  output wire sdout,
  output wire dma_tx_req,
  output wire dma_rx_req,
  output wire irq
);

  // ***********************************************************
  // Functions
  // ***********************************************************
  function [5:0] size_bits;
    input [1:0] code;
    begin
      case (code)
        2'h0: size_bits = 6'h08;
        2'h1: size_bits = 6'h10;
        2'h2: size_bits = 6'h18;
        default: size_bits = 6'h20;
      endcase
    end
  endfunction

  // Level of the frame sync for a given bit position.
  function fs_level;
    input [1:0] fmt;
    input [5:0] pos;
    input [2:0] slot;
    begin
      case (fmt)
        `ASP_FMT_STD: fs_level = (slot != 3'h0);
        `ASP_FMT_TDM: fs_level = (slot == 3'h0) && (pos == 6'h00);
        default: fs_level = (slot == 3'h0);
      endcase
    end
  endfunction

  // ***********************************************************
  // Registers and declarations
  // ***********************************************************
  reg [`ASP_CTRL_W-1:0] ctrl_ff;
  reg [7:0] clkdiv_ff;
  reg [`ASP_TDM_W-1:0] tdm_ff;
  reg [`ASP_INT_W-1:0] stat_ff;
  reg [`ASP_INT_W-1:0] mask_ff;
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg irq_ff;
  reg dma_tx_ff;
  reg dma_rx_ff;
  reg bclk_s1_ff, bclk_s2_ff, bclk_s3_ff;
  reg fs_s1_ff, fs_s2_ff, fs_s3_ff;
  reg sd_s1_ff, sd_s2_ff;
  reg [7:0] div_ff;
  reg bclk_ff;
  reg fs_ff;
  reg [5:0] pos_ff;
  reg [2:0] slot_ff;
  reg [31:0] tx_sr_ff;
  reg [31:0] last_ff;
  reg [31:0] rx_sr_ff;
  reg [5:0] rcnt_ff;

  wire tx_en = ctrl_ff[`ASP_CTRL_TXEN];
  wire rx_en = ctrl_ff[`ASP_CTRL_RXEN];
  wire master = ctrl_ff[`ASP_CTRL_MASTER];
  wire [1:0] fmt = ctrl_ff[`ASP_CTRL_FMT];
  wire rx_rst = ctrl_ff[`ASP_CTRL_RXRST];
  wire active = tx_en || rx_en;
  wire [5:0] size = size_bits(ctrl_ff[`ASP_CTRL_SIZE]);

  wire tx_wr_ready, tx_rd_valid, rx_wr_ready, rx_rd_valid;
  wire [31:0] tx_rd_data, rx_rd_data;
  reg tx_pop;
  reg rx_push;
  reg [31:0] rx_word;

  // ***********************************************************
  // APB slave
  // ***********************************************************
  wire setup = psel && !penable;
  wire acc = psel && penable && pready_ff;
  wire wr_acc = acc && pwrite;
  wire rd_acc = acc && !pwrite;
  wire tx_push = wr_acc && (paddr == `ASP_OFF_TXDATA);
  wire rx_pop = rd_acc && (paddr == `ASP_OFF_RXDATA);
  wire stat_rd = rd_acc && (paddr == `ASP_OFF_INTSTAT);

  reg [31:0] rd_mux;
  reg mapped;
  always @* begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `ASP_OFF_CTRL: rd_mux[`ASP_CTRL_W-1:0] = ctrl_ff;
      `ASP_OFF_CLKDIV: rd_mux[7:0] = clkdiv_ff;
      `ASP_OFF_TDM: rd_mux[`ASP_TDM_W-1:0] = tdm_ff;
      `ASP_OFF_TXDATA: rd_mux = 32'h0000_0000;
      `ASP_OFF_RXDATA: rd_mux = rx_rd_valid ? rx_rd_data : 32'h0000_0000;
      `ASP_OFF_STATUS: rd_mux[3:0] = {!rx_rd_valid, !rx_wr_ready,
                                      !tx_rd_valid, !tx_wr_ready};
      `ASP_OFF_INTSTAT: rd_mux[`ASP_INT_W-1:0] = stat_ff;
      `ASP_OFF_INTMASK: rd_mux[`ASP_INT_W-1:0] = mask_ff;
      default: mapped = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `ASP_CTRL_RST;
      clkdiv_ff <= `ASP_CLKDIV_RST;
      tdm_ff <= `ASP_TDM_RST;
      mask_ff <= {`ASP_INT_W{1'b0}};
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff <= rd_mux;
        pslverr_ff <= !mapped;
      end else if (acc) begin
        pslverr_ff <= 1'b0;
      end
      if (wr_acc) begin
        case (paddr)
          `ASP_OFF_CTRL: ctrl_ff <= pwdata[`ASP_CTRL_W-1:0];
          `ASP_OFF_CLKDIV: clkdiv_ff <= pwdata[7:0];
          `ASP_OFF_TDM: tdm_ff <= pwdata[`ASP_TDM_W-1:0];
          `ASP_OFF_INTMASK: mask_ff <= pwdata[`ASP_INT_W-1:0];
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bclk_s1_ff <= 1'b0;
      bclk_s2_ff <= 1'b0;
      bclk_s3_ff <= 1'b0;
      fs_s1_ff <= 1'b0;
      fs_s2_ff <= 1'b0;
      fs_s3_ff <= 1'b0;
      sd_s1_ff <= 1'b0;
      sd_s2_ff <= 1'b0;
    end else begin
      bclk_s1_ff <= bclk_i;
      bclk_s2_ff <= bclk_s1_ff;
      bclk_s3_ff <= bclk_s2_ff;
      fs_s1_ff <= fs_i;
      fs_s2_ff <= fs_s1_ff;
      fs_s3_ff <= fs_s2_ff;
      sd_s1_ff <= sdin;
      sd_s2_ff <= sd_s1_ff;
    end
  end

  // ***********************************************************
  // Bit clock: divider as master, edge finder as slave
  // ***********************************************************
  // Half period is clkdiv+1 cycles; the divider sets the frame rate.
  // The input path adds two cycles, so keep clkdiv at 2 or more.
  wire tick = (div_ff == clkdiv_ff);
  // clock source chosen by master bit
  wire rise_ev = master ? (active && tick && !bclk_ff)
                        : (bclk_s2_ff && !bclk_s3_ff);
  wire fall_ev = master ? (active && tick && bclk_ff)
                        : (!bclk_s2_ff && bclk_s3_ff);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= 8'h00;
      bclk_ff <= 1'b0;
    end else if (!master || !active) begin
      div_ff <= 8'h00;
      bclk_ff <= 1'b0;
    end else if (tick) begin
      div_ff <= 8'h00;
      bclk_ff <= !bclk_ff;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // ***********************************************************
  // Frame position
  // ***********************************************************
  // standard slot width fixed
  wire tdm = (fmt == `ASP_FMT_TDM);
  wire [5:0] slotw = tdm ? size_bits(tdm_ff[`ASP_TDM_SLOT]) : `ASP_STD_SLOTW;
  wire [2:0] last_slot = tdm ? tdm_ff[`ASP_TDM_CH] : `ASP_STD_LAST;
  wire start_lvl = (fmt != `ASP_FMT_STD);
  // Sync moves with the falling bit clock, so both cross the synchronisers
  // together; a frame start is thus seen on the fall that opens bit zero.
  wire fstart = !master && fall_ev && (fs_s2_ff == start_lvl) &&
                (fs_s3_ff != start_lvl);
  wire [5:0] cur_pos = fstart ? 6'h00 : pos_ff;
  wire [5:0] nxt_pos = fstart ? 6'h00 :
                       (pos_ff == slotw - 6'h01) ? 6'h00 : pos_ff + 6'h01;
  wire [2:0] nxt_slot = fstart ? 3'h0 :
                        (pos_ff != slotw - 6'h01) ? slot_ff :
                        (slot_ff == last_slot) ? 3'h0 : slot_ff + 3'h1;

  // one bit delay in standard and TDM
  wire dly = (fmt == `ASP_FMT_STD) || tdm;
  wire [5:0] off = (fmt == `ASP_FMT_RJ) ? slotw - size : 6'h00;
  wire [5:0] start = off + {5'h00, dly};

  // one clock and sync for both paths
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_ff <= 6'h00;
      slot_ff <= 3'h0;
      fs_ff <= 1'b0;
    end else if (!active) begin
      pos_ff <= 6'h00;
      slot_ff <= 3'h0;
      fs_ff <= 1'b0;
    end else if (fstart) begin
      pos_ff <= 6'h00;
      slot_ff <= 3'h0;
    end else if (fall_ev) begin
      pos_ff <= nxt_pos;
      slot_ff <= nxt_slot;
      fs_ff <= master && fs_level(fmt, nxt_pos, nxt_slot);
    end
  end

  // ***********************************************************
  // Serializer
  // ***********************************************************
  reg [31:0] tx_sample;
  reg tx_und;
  always @* begin
    tx_pop = 1'b0;
    tx_und = 1'b0;
    tx_sample = 32'h0000_0000;
    if (tx_en && fall_ev && nxt_pos == start) begin
      if (tx_rd_valid) begin
        tx_pop = 1'b1;
        tx_sample = tx_rd_data;
      end else begin
        tx_und = 1'b1;
        tx_sample = ctrl_ff[`ASP_CTRL_ZERO] ? 32'h0000_0000 : last_ff;
      end
    end
  end

  // load and shift out MSB first
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_sr_ff <= 32'h0000_0000;
      last_ff <= 32'h0000_0000;
    end else if (!tx_en) begin
      tx_sr_ff <= 32'h0000_0000;
    end else if (fall_ev) begin
      if (nxt_pos == start) begin
        tx_sr_ff <= tx_sample << (`ASP_WORD - size);
        if (tx_pop) begin
          last_ff <= tx_rd_data;
        end
      end else begin
        tx_sr_ff <= {tx_sr_ff[30:0], 1'b0};
      end
    end
  end

  // ***********************************************************
  // Deserializer
  // ***********************************************************
  // A zero count means idle, so bits before the first slot are ignored.
  wire rx_go = rx_en && !rx_rst && rise_ev;
  wire rx_first = (cur_pos == start);
  wire [5:0] rx_cnt = rx_first ? 6'h01 : rcnt_ff + 6'h01;
  wire rx_take = rx_go && (rx_first || rcnt_ff != 6'h00);
  wire rx_done = rx_take && (rx_cnt == size);
  wire rx_ovf = rx_done && !rx_wr_ready;

  always @* begin
    rx_word = rx_first ? {31'h0000_0000, sd_s2_ff}
                       : {rx_sr_ff[30:0], sd_s2_ff};
    rx_push = rx_done && rx_wr_ready;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sr_ff <= 32'h0000_0000;
      rcnt_ff <= 6'h00;
    end else if (!rx_en || rx_rst) begin
      rx_sr_ff <= 32'h0000_0000;
      rcnt_ff <= 6'h00;
    end else if (rx_take) begin
      rx_sr_ff <= rx_word;
      rcnt_ff <= rx_done ? 6'h00 : rx_cnt;
    end
  end

  // ***********************************************************
  // FIFOs
  // ***********************************************************
  asp_fifo #(.W(32), .AW(FIFO_AW)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .wr_valid(tx_push),
    .wr_data(pwdata),
    .wr_ready(tx_wr_ready),
    .rd_valid(tx_rd_valid),
    .rd_ready(tx_pop),
    .rd_data(tx_rd_data)
  );

  asp_fifo #(.W(32), .AW(FIFO_AW)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .wr_valid(rx_push),
    .wr_data(rx_word),
    .wr_ready(rx_wr_ready),
    .rd_valid(rx_rd_valid),
    .rd_ready(rx_pop),
    .rd_data(rx_rd_data)
  );

  // ***********************************************************
  // Status, interrupt and DMA requests
  // ***********************************************************
  // A read clears only the bits it returned; a new event wins over it.
  wire [`ASP_INT_W-1:0] ev;
  assign ev[`ASP_INT_RXOVF] = rx_ovf;
  assign ev[`ASP_INT_TXUND] = tx_und;
  wire [`ASP_INT_W-1:0] clr = stat_rd ? prdata_ff[`ASP_INT_W-1:0]
                                      : {`ASP_INT_W{1'b0}};
  wire [`ASP_INT_W-1:0] nxt_stat = (stat_ff & ~clr) | ev;

  // each path enabled on its own
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_ff <= {`ASP_INT_W{1'b0}};
      irq_ff <= 1'b0;
      dma_tx_ff <= 1'b0;
      dma_rx_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff <= |(nxt_stat & mask_ff);
      dma_tx_ff <= ctrl_ff[`ASP_CTRL_TXDMA] && tx_en && tx_wr_ready;
      dma_rx_ff <= ctrl_ff[`ASP_CTRL_RXDMA] && rx_rd_valid;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign bclk_o = bclk_ff;
  assign bclk_oe = master;
  assign fs_o = fs_ff;
  assign fs_oe = master;
  assign sdout = tx_sr_ff[31];
  assign dma_tx_req = dma_tx_ff;
  assign dma_rx_req = dma_rx_ff;
  assign irq = irq_ff;
endmodule

// file: testbench/asp_properties.sv
// Assertions on the audio port's bus and serial pins.
`timescale 1ns/1ns
module asp_properties (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire bclk_o,
  input wire bclk_oe,
  input wire fs_o,
  input wire fs_oe,
  input wire sdout,
  input wire dma_rx_req,
  input wire irq
);
  logic [3:0] acc_ff;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************
  // Bus history
  // ****************
  // A recent bus answer excuses changes that software itself caused.
  always @(posedge clk or posedge rst) begin
    if (rst)
      acc_ff <= 4'h0;
    else
      acc_ff <= {acc_ff[2:0], pready};
  end
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no ready after setup");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("ready longer than one cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_oe_pair;
    bclk_oe == fs_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("clock and sync drive differ");
  property p_bclk_hold;
    bclk_oe && $changed(bclk_o) |=> $stable(bclk_o) [*2];
  endproperty
  a_bclk_hold: assert property (p_bclk_hold)
    else $error("bit clock half period too short");
  property p_sd_fall;
    bclk_oe && $changed(sdout) |-> $fell(bclk_o) || (|acc_ff);
  endproperty
  a_sd_fall: assert property (p_sd_fall)
    else $error("data changed off the falling edge");
  property p_fs_fall;
    bclk_oe && $changed(fs_o) |-> $fell(bclk_o) || (|acc_ff);
  endproperty
  a_fs_fall: assert property (p_fs_fall)
    else $error("sync changed off the falling edge");
  property p_rxreq_fall;
    $fell(dma_rx_req) |-> |acc_ff;
  endproperty
  a_rxreq_fall: assert property (p_rxreq_fall)
    else $error("receive request dropped without access");
  property p_irq_fall;
    $fell(irq) |-> |acc_ff;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without access");
endmodule
bind asp_top asp_properties u_asp_properties (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .fs_o(fs_o),
  .fs_oe(fs_oe), .sdout(sdout), .dma_rx_req(dma_rx_req), .irq(irq)
);

// file: testbench/asp_codec_model.sv
// Far-side codec model: frames clock and sync on request, moves samples.
`timescale 1ns/1ns
module asp_codec_model (
  input wire gen,
  input wire [5:0] nbits,
  input wire [31:0] word_l,
  input wire [31:0] word_r,
  input wire bclk,
  input wire fs,
  input wire sdout,
  output logic mbclk,
  output logic mfs,
  output logic sdin,
  output logic [31:0] cap_l,
  output logic [31:0] cap_r,
  output int nfr
);
  int pos = 0;
  int np;
  logic fs_ff = 1'h1;
  logic sd_ff = 1'h0;
  logic [31:0] sh;
  assign sdin = sd_ff;
  // ****************
  // Frame source
  // ****************
  // whole frames only
  // The clock stands still high between frames, so a frame starts on a fall.
  initial begin
    {mbclk, mfs} = 2'h3;
    nfr = 0;
    // Clock and sync update together after any clock edge in that step.
    forever begin
      wait (gen);
      for (int b = 0; b < 64; b++) begin
        #62 mbclk <= 1'h0;
        mfs <= b >= 32;
        #63 mbclk <= 1'h1;
      end
      nfr++;
    end
  end
  always @(posedge bclk) begin
    pos = (fs !== fs_ff) ? 0 : pos + 1;
    fs_ff = fs;
    if (pos == 0)
      sh = 32'h0;
    else if (pos <= nbits)
      sh = {sh[30:0], sdout};
    if (pos == nbits && fs)
      cap_r = sh;
    else if (pos == nbits)
      cap_l = sh;
  end
  // sender timing
  // Outside the data bits the line toggles, so stale values never match.
  always @(negedge bclk) begin
    #1;
    np = (fs !== fs_ff) ? 0 : pos + 1;
    if (np >= 1 && np <= nbits)
      sd_ff = fs ? word_r[nbits - np] : word_l[nbits - np];
    else
      sd_ff = ~sd_ff;
  end
endmodule

// file: testbench/test_asp_top.sv
// Self-checking bench for the audio port with a codec model.
`timescale 1ns/1ns
`include "asp_consts.vh"
module test_asp_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, sdin, sdout;
  logic bclk_o, bclk_oe, fs_o, fs_oe, dma_tx_req, dma_rx_req, irq;
  logic gen, mbclk, mfs, er;
  logic [7:0] paddr;
  logic [5:0] nbits;
  logic [31:0] pwdata, prdata, word_l, word_r, cap_l, cap_r, rd, n, msk;
  int nfr, n_errors, n_tests;
  wire bclk = bclk_oe ? bclk_o : mbclk;
  wire fs = fs_oe ? fs_o : mfs;
  logic [72:0] tbl [10] = '{
    {1'h0, `ASP_OFF_CTRL, 32'h0, 32'h100},
    {1'h0, `ASP_OFF_CLKDIV, 32'h0, 32'h7},
    {1'h0, `ASP_OFF_TDM, 32'h0, 32'h1F},
    {1'h0, `ASP_OFF_STATUS, 32'h0, 32'hA},
    {1'h0, `ASP_OFF_INTSTAT, 32'h0, 32'h0},
    {1'h0, 8'h20, 32'h0, 32'h0},
    {1'h1, 8'h20, 32'h55, 32'h0},
    {1'h1, `ASP_OFF_INTMASK, 32'h3, 32'h0},
    {1'h0, `ASP_OFF_INTMASK, 32'h0, 32'h3},
    {1'h1, `ASP_OFF_INTMASK, 32'h0, 32'h0}
  };
  asp_top #(.FIFO_AW(2)) u_asp_top (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bclk_i(bclk), .bclk_o(bclk_o), .bclk_oe(bclk_oe),
    .fs_i(fs), .fs_o(fs_o), .fs_oe(fs_oe), .sdin(sdin), .sdout(sdout),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .irq(irq)
  );
  asp_codec_model u_asp_codec_model (
    .gen(gen), .nbits(nbits), .word_l(word_l), .word_r(word_r),
    .bclk(bclk), .fs(fs), .sdout(sdout), .mbclk(mbclk), .mfs(mfs),
    .sdin(sdin), .cap_l(cap_l), .cap_r(cap_r), .nfr(nfr)
  );
  // ****************
  // Tasks
  // ****************
  task end_of_test;
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task fail_wait;
    n_errors++;
    $display("MISMATCH %0t wait ran out", $time);
    end_of_test;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    if (pready !== 1'h1)
      fail_wait;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  // Gen drops during the last frame so the model stops on a frame boundary.
  task frames(input int k);
    k = k + nfr;
    gen <= 1'h1;
    for (int j = 0; j < 5000 && nfr < k; j++) begin
      @(posedge clk);
      if (nfr >= k - 1)
        gen <= 1'h0;
    end
    if (nfr < k)
      fail_wait;
  endtask
  task push2;
    apb(1'h1, `ASP_OFF_TXDATA, 32'h00A55A3C & msk);
    apb(1'h1, `ASP_OFF_TXDATA, 32'h0069C31E & msk);
  endtask
  task pop2;
    rdchk(`ASP_OFF_RXDATA, 32'h5A3C96E1 & msk);
    rdchk(`ASP_OFF_RXDATA, 32'hC3A51E69 & msk);
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    {n_errors, n_tests} = '0;
    {rst, psel, penable, pwrite, gen} = 5'h10;
    {paddr, pwdata, nbits} = '0;
    word_l = 32'h5A3C96E1;
    word_r = 32'hC3A51E69;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    foreach (tbl[i]) begin
      apb(tbl[i][72], tbl[i][71:64], tbl[i][63:32]);
      if (!tbl[i][72])
        chk(rd, tbl[i][31:0]);
      chk({31'h0, er}, {31'h0, tbl[i][71:64] > 8'h1C});
    end
    for (int s = 0; s < 3; s++) begin
      msk = (32'h1 << (8 * s + 8)) - 32'h1;
      nbits <= 6'(8 * s + 8);
      apb(1'h1, `ASP_OFF_CTRL, 32'h100 | 32'(s << 5));
      apb(1'h1, `ASP_OFF_CTRL, 32'h603 | 32'(s << 5));
      repeat (2) push2;
      rdchk(`ASP_OFF_STATUS, 32'h9);
      chk(dma_tx_req, 32'h0);
      frames(2);
      chk(cap_l, 32'h00A55A3C & msk);
      chk(cap_r, 32'h0069C31E & msk);
      repeat (2) pop2;
    end
    push2;
    frames(3);
    chk(cap_l, 32'h0069C31E & msk);
    chk(irq, 32'h0);
    chk(dma_rx_req, 32'h1);
    chk(dma_tx_req, 32'h1);
    rdchk(`ASP_OFF_STATUS, 32'h6);
    apb(1'h1, `ASP_OFF_INTMASK, 32'h1);
    rdchk(`ASP_OFF_INTMASK, 32'h1);
    chk(irq, 32'h1);
    rdchk(`ASP_OFF_INTSTAT, 32'h3);
    rdchk(`ASP_OFF_INTSTAT, 32'h0);
    chk(irq, 32'h0);
    repeat (2) pop2;
    rdchk(`ASP_OFF_RXDATA, 32'h0);
    chk(dma_rx_req, 32'h0);
    apb(1'h1, `ASP_OFF_CTRL, 32'h42);
    frames(1);
    chk(sdout, 32'h0);
    rdchk(`ASP_OFF_RXDATA, 32'h5A3C96E1 & msk);
    apb(1'h1, `ASP_OFF_CTRL, 32'hC1);
    frames(1);
    chk(cap_r, 32'h0);
    // formats as master
    // Two 32-bit slots give a 1024-cycle frame, so any window sees one frame.
    apb(1'h1, `ASP_OFF_TDM, 32'h19);
    for (int f = 0; f < 4; f++) begin
      apb(1'h1, `ASP_OFF_CTRL, 32'h65 | 32'(f << 3));
      repeat (1100) @(posedge clk);
      n = 0;
      repeat (1024) begin
        @(posedge clk);
        n = n + fs_o;
      end
      chk(n, f == 3 ? 32'h10 : 32'h200);
    end
    chk(bclk_oe, 32'h1);
    end_of_test;
  end
endmodule
